// ### design/idw_defs.svh
// Offsets, field positions, reset values and fixed word contents
// Assumes inclusion by bare name from the identify word design files
`ifndef IDW_DEFS_SVH
`define IDW_DEFS_SVH

// ----------------------------------------
// Command and sector
// ----------------------------------------
`define IDW_CMD_IDENTIFY 8'hec
`define IDW_SECTOR_WORDS 256
`define IDW_LAST_IDX 8'hff

// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define IDW_OFF_CTRL 8'h00
`define IDW_OFF_GEOM 8'h04
`define IDW_OFF_SPT 8'h08
`define IDW_OFF_CURCAP 8'h0c
`define IDW_OFF_MULT 8'h10
`define IDW_OFF_NATLO 8'h14
`define IDW_OFF_NATHI 8'h18
`define IDW_OFF_DMAACT 8'h1c
`define IDW_OFF_SATAEN 8'h20
`define IDW_OFF_STATUS 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IDW_CTRL_STD_BIT 0
`define IDW_CTRL_GEN2_BIT 1
`define IDW_MULT_VALID_BIT 8
`define IDW_W49_STD_BIT 13
`define IDW_W76_GEN2_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IDW_RST_CTRL 2'h3
`define IDW_RST_SATAEN 16'h0040
`define IDW_SATAEN_MASK 16'h005e

// ----------------------------------------
// Word indices and fixed contents
// ----------------------------------------
`define IDW_W49_BASE 16'h0f00
`define IDW_W50 16'h4000
`define IDW_W51 16'h0200
`define IDW_W52 16'h0200
`define IDW_W53 16'h0007
`define IDW_W62 16'h0000
`define IDW_W63_MODES 8'h07
`define IDW_W64 16'h0003
`define IDW_CYCLE_NS 16'h0078
`define IDW_W75 16'h001f
`define IDW_W76_BASE 16'h1702
`define IDW_W78 16'h005e
`define IDW_W80 16'h01fc
`define IDW_W81 16'h0029
`define IDW_RSV 16'h0000
`define IDW_CAP_LIMIT 48'h00000fffffff
`define IDW_CAP_SAT 32'h00ffffff

`endif

// ### design/idw_pkg.sv
// Types shared by the identify capability word block
// Assumes idw_defs.svh sits on the include path
package idw_pkg;

  typedef enum logic [2:0] {
    IDW_IDLE = 3'b001,
    IDW_SEND = 3'b010,
    IDW_DRAIN = 3'b100
  } idw_state_t;

  typedef struct packed {
    idw_state_t st;
    logic [7:0] idx;
    logic out_valid;
    logic [15:0] out_data;
    logic [7:0] out_idx;
    logic done;
    logic [15:0] sent_cnt;
    logic [1:0] ctrl;
    logic [15:0] cyl;
    logic [15:0] heads;
    logic [15:0] spt;
    logic [31:0] cur_cap;
    logic [8:0] mult;
    logic [47:0] native;
    logic [7:0] dma_act;
    logic [15:0] sata_en;
    logic [31:0] prdata;
    logic pslverr;
  } idw_regs_t;

endpackage

// ### design/idw_cap_calc.sv
// Saturating user capacity from the native maximum address
// Assumes a plain combinational context
`timescale 1ns/1ps
`include "idw_defs.svh"
module idw_cap_calc (
  // Native maximum address
  input wire logic [47:0] native_max,
  // Reported capacity
  output logic [31:0] user_cap
);

  // ----------------------------------------
  // Saturation
  // ----------------------------------------
  always_comb begin
    if (native_max > `IDW_CAP_LIMIT) begin
      user_cap = `IDW_CAP_SAT;
    end else begin
      user_cap = native_max[31:0];
    end
  end

endmodule

// ### design/idw_word_mux.sv
// Content of each identify word from its index and configuration
// Assumes all inputs come from registers on the core clock
`timescale 1ns/1ps
`include "idw_defs.svh"
module idw_word_mux (
  // Word select
  input wire logic [7:0] word_idx,
  // Configuration
  input wire logic std_timer,
  input wire logic gen2,
  input wire logic [15:0] cyl,
  input wire logic [15:0] heads,
  input wire logic [15:0] spt,
  input wire logic [31:0] cur_cap,
  input wire logic [8:0] mult,
  input wire logic [31:0] user_cap,
  input wire logic [7:0] dma_act,
  input wire logic [15:0] sata_en,
  // Word content
  output logic [15:0] word_data
);

  // ----------------------------------------
  // Word table
  // ----------------------------------------
  always_comb begin
    case (word_idx)
      8'd49: begin
        word_data = `IDW_W49_BASE;
        word_data[`IDW_W49_STD_BIT] = std_timer;
      end
      8'd50: word_data = `IDW_W50;
      8'd51: word_data = `IDW_W51;
      8'd52: word_data = `IDW_W52;
      8'd53: word_data = `IDW_W53;
      8'd54: word_data = cyl;
      8'd55: word_data = heads;
      8'd56: word_data = spt;
      8'd57: word_data = cur_cap[15:0];
      8'd58: word_data = cur_cap[31:16];
      8'd59: word_data = {7'h00, mult};
      8'd60: word_data = user_cap[15:0];
      8'd61: word_data = user_cap[31:16];
      8'd62: word_data = `IDW_W62;
      8'd63: word_data = {dma_act, `IDW_W63_MODES};
      8'd64: word_data = `IDW_W64;
      8'd65, 8'd66, 8'd67, 8'd68: word_data = `IDW_CYCLE_NS;
      8'd75: word_data = `IDW_W75;
      8'd76: begin
        word_data = `IDW_W76_BASE;
        word_data[`IDW_W76_GEN2_BIT] = gen2;
      end
      8'd78: word_data = `IDW_W78;
      8'd79: word_data = sata_en & `IDW_SATAEN_MASK;
      8'd80: word_data = `IDW_W80;
      8'd81: word_data = `IDW_W81;
      default: word_data = `IDW_RSV;
    endcase
  end

endmodule

// ### design/idw_top.sv
// Identify capability words 49..81 with APB configuration
// Assumes command and word consumer run on core_clk
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "idw_defs.svh"
module idw_top #(
  parameter int PADDR_W = 8,
  parameter int SECTOR_WORDS = `IDW_SECTOR_WORDS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command input
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  output logic cmd_ready,
  // Word stream out
  output logic word_valid,
  input wire logic word_ready,
  output logic [7:0] word_index,
  output logic [15:0] word_data,
  output logic sector_done
);
  import idw_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (SECTOR_WORDS != `IDW_SECTOR_WORDS) begin : g_chk_words
    $error("idw_top: sector length must be 256 words");
  end
  if (PADDR_W < 8) begin : g_chk_addr
    $error("idw_top: PADDR_W must cover the 8-bit register offsets");
  end

  localparam idw_regs_t RST = '{
    st: IDW_IDLE, idx: 8'h00, out_valid: 1'b0, out_data: 16'h0000,
    out_idx: 8'h00, done: 1'b0, sent_cnt: 16'h0000,
    ctrl: `IDW_RST_CTRL, cyl: 16'h0000, heads: 16'h0000, spt: 16'h0000,
    cur_cap: 32'h00000000, mult: 9'h000, native: 48'h000000000000,
    dma_act: 8'h00, sata_en: `IDW_RST_SATAEN, prdata: 32'h00000000,
    pslverr: 1'b0
  };

  idw_regs_t r_reg;
  idw_regs_t r_next;
  logic [31:0] user_cap;
  logic [15:0] cur_word;
  logic [7:0] off;
  logic acc;
  logic wr_en;
  logic rd_setup;

  // ----------------------------------------
  // Content generation
  // ----------------------------------------
  idw_cap_calc u_cap (
    .native_max(r_reg.native),
    .user_cap(user_cap)
  );

  idw_word_mux u_mux (
    .word_idx(r_reg.idx),
    .std_timer(r_reg.ctrl[`IDW_CTRL_STD_BIT]),
    .gen2(r_reg.ctrl[`IDW_CTRL_GEN2_BIT]),
    .cyl(r_reg.cyl),
    .heads(r_reg.heads),
    .spt(r_reg.spt),
    .cur_cap(r_reg.cur_cap),
    .mult(r_reg.mult),
    .user_cap(user_cap),
    .dma_act(r_reg.dma_act),
    .sata_en(r_reg.sata_en),
    .word_data(cur_word)
  );

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  function automatic logic [32:0] rd_mux(input logic [7:0] a, input idw_regs_t s);
    case (a)
      `IDW_OFF_CTRL: rd_mux = {1'b1, 30'h0, s.ctrl};
      `IDW_OFF_GEOM: rd_mux = {1'b1, s.heads, s.cyl};
      `IDW_OFF_SPT: rd_mux = {1'b1, 16'h0000, s.spt};
      `IDW_OFF_CURCAP: rd_mux = {1'b1, s.cur_cap};
      `IDW_OFF_MULT: rd_mux = {1'b1, 23'h0, s.mult};
      `IDW_OFF_NATLO: rd_mux = {1'b1, s.native[31:0]};
      `IDW_OFF_NATHI: rd_mux = {1'b1, 16'h0000, s.native[47:32]};
      `IDW_OFF_DMAACT: rd_mux = {1'b1, 24'h0, s.dma_act};
      `IDW_OFF_SATAEN: rd_mux = {1'b1, 16'h0000, s.sata_en};
      `IDW_OFF_STATUS: rd_mux = {1'b1, s.sent_cnt, 13'h0, s.st};
      default: rd_mux = 33'h000000000;
    endcase
  endfunction

  assign off = paddr[7:0];
  assign acc = r_reg.out_valid && word_ready;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [32:0] rd;
    rd = rd_mux(off, r_reg);
    r_next = r_reg;
    r_next.done = 1'b0;
    if (acc) begin
      r_next.out_valid = 1'b0;
    end
    case (r_reg.st)
      IDW_IDLE: begin
        if (cmd_valid && cmd_opcode == `IDW_CMD_IDENTIFY) begin
          r_next.st = IDW_SEND;
          r_next.idx = 8'h00;
        end
      end
      IDW_SEND: begin
        if (!r_reg.out_valid || word_ready) begin
          r_next.out_valid = 1'b1;
          r_next.out_data = cur_word;
          r_next.out_idx = r_reg.idx;
          r_next.idx = r_reg.idx + 8'h01;
          if (r_reg.idx == `IDW_LAST_IDX) begin
            r_next.st = IDW_DRAIN;
          end
        end
      end
      IDW_DRAIN: begin
        if (acc) begin
          r_next.st = IDW_IDLE;
          r_next.done = 1'b1;
          r_next.sent_cnt = r_reg.sent_cnt + 16'h0001;
        end
      end
      default: r_next.st = IDW_IDLE;
    endcase
    if (rd_setup) begin
      r_next.prdata = pwrite ? 32'h00000000 : rd[31:0];
      r_next.pslverr = !rd[32];
    end
    if (wr_en) begin
      case (off)
        `IDW_OFF_CTRL: r_next.ctrl = pwdata[1:0];
        `IDW_OFF_GEOM: begin
          r_next.cyl = pwdata[15:0];
          r_next.heads = pwdata[31:16];
        end
        `IDW_OFF_SPT: r_next.spt = pwdata[15:0];
        `IDW_OFF_CURCAP: r_next.cur_cap = pwdata;
        `IDW_OFF_MULT: r_next.mult = pwdata[8:0];
        `IDW_OFF_NATLO: r_next.native[31:0] = pwdata;
        `IDW_OFF_NATHI: r_next.native[47:32] = pwdata[15:0];
        `IDW_OFF_DMAACT: r_next.dma_act = pwdata[7:0];
        `IDW_OFF_SATAEN: r_next.sata_en = pwdata[15:0] & `IDW_SATAEN_MASK;
        default: r_next.ctrl = r_reg.ctrl;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = psel && penable;
  assign prdata = r_reg.prdata;
  assign pslverr = pready && r_reg.pslverr;
  assign cmd_ready = (r_reg.st == IDW_IDLE);
  assign word_valid = r_reg.out_valid;
  assign word_index = r_reg.out_idx;
  assign word_data = r_reg.out_data;
  assign sector_done = r_reg.done;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [31:0] cap_exp;
  assign cap_exp = (r_reg.native > `IDW_CAP_LIMIT) ? `IDW_CAP_SAT : r_reg.native[31:0];

  sequence s_start;
    cmd_ready && cmd_valid && cmd_opcode == `IDW_CMD_IDENTIFY;
  endsequence
  sequence s_first_word;
    word_valid && word_index == 8'h00;
  endsequence
  sequence s_last_taken;
    word_valid && word_ready && word_index == `IDW_LAST_IDX;
  endsequence

  property p_start;
    s_start |=> !cmd_ready ##1 s_first_word;
  endproperty
  a_start: assert property (p_start) else $error("identify did not start");

  property p_end;
    s_last_taken |=> sector_done && cmd_ready && !word_valid;
  endproperty
  a_end: assert property (p_end) else $error("sector end missing");

  property p_w49;
    word_valid && word_index == 8'd49 |->
      (word_data & 16'hdfff) == `IDW_W49_BASE;
  endproperty
  a_w49: assert property (p_w49) else $error("word 49 bad");

  property p_w49_std;
    word_valid && word_index == 8'd49 |->
      word_data[`IDW_W49_STD_BIT] == r_reg.ctrl[`IDW_CTRL_STD_BIT];
  endproperty
  a_w49_std: assert property (p_w49_std) else $error("word 49 bit 13 bad");

  property p_fixed;
    word_valid |->
      (word_index != 8'd50 || word_data == `IDW_W50) &&
      (word_index != 8'd51 || word_data == `IDW_W51) &&
      (word_index != 8'd53 || word_data == `IDW_W53);
  endproperty
  a_fixed: assert property (p_fixed) else $error("word 50/51/53 bad");

  property p_w57;
    word_valid && word_index == 8'd57 && $stable(r_reg.cur_cap) |->
      word_data == r_reg.cur_cap[15:0];
  endproperty
  a_w57: assert property (p_w57) else $error("word 57 bad");

  property p_w59;
    word_valid && word_index == 8'd59 |-> word_data[15:9] == 7'h00;
  endproperty
  a_w59: assert property (p_w59) else $error("word 59 bad");

  property p_w61;
    word_valid && word_index == 8'd61 && $stable(r_reg.native) |->
      word_data == cap_exp[31:16];
  endproperty
  a_w61: assert property (p_w61) else $error("word 61 bad");

  property p_modes;
    word_valid |->
      (word_index != 8'd62 || word_data == `IDW_W62) &&
      (word_index != 8'd63 || word_data[7:0] == `IDW_W63_MODES) &&
      (word_index != 8'd64 || word_data == `IDW_W64);
  endproperty
  a_modes: assert property (p_modes) else $error("word 62-64 bad");

  property p_cycle;
    word_valid && word_index >= 8'd65 && word_index <= 8'd68 |->
      word_data == `IDW_CYCLE_NS;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle time word bad");

  property p_rsv;
    word_valid && (word_index == 8'd77 ||
      (word_index >= 8'd69 && word_index <= 8'd74)) |-> word_data == `IDW_RSV;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word nonzero");

  property p_sata;
    word_valid |->
      (word_index != 8'd75 || word_data == `IDW_W75) &&
      (word_index != 8'd76 || (word_data & 16'hfffb) == `IDW_W76_BASE) &&
      (word_index != 8'd78 || word_data == `IDW_W78);
  endproperty
  a_sata: assert property (p_sata) else $error("serial word bad");

  // First edge after release: enabled features and control at reset values
  property p_sataen_rst;
    $past(sys_rst) |->
      r_reg.sata_en == `IDW_RST_SATAEN && r_reg.ctrl == `IDW_RST_CTRL;
  endproperty
  a_sataen_rst: assert property (p_sataen_rst) else $error("w79 reset bad");

  property p_ver;
    word_valid |->
      (word_index != 8'd80 || word_data == `IDW_W80) &&
      (word_index != 8'd81 || word_data == `IDW_W81);
  endproperty
  a_ver: assert property (p_ver) else $error("version word bad");

  property p_order;
    word_valid && word_ready && word_index != `IDW_LAST_IDX |=>
      word_valid && word_index == $past(word_index) + 8'h01;
  endproperty
  a_order: assert property (p_order) else $error("word out of order");

endmodule

// ### tb/idw_host_model.sv
// Host side model: issues commands and accepts identify words
// Assumes the bench pulses go for one cycle and reset is active high
`timescale 1ns/1ps
module idw_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bench control
  input wire logic go,
  input wire logic [7:0] opc,
  input wire logic [7:0] hold_cyc,
  input wire logic slow,
  // Command to device
  output logic cmd_valid = 1'b0,
  output logic [7:0] cmd_opcode = 8'h00,
  input wire logic cmd_ready,
  // Word stream from device
  input wire logic word_valid,
  output logic word_ready = 1'b0
);
  logic [7:0] held;
  logic [15:0] lfsr;
  logic taken;

  // ----------------------------------------
  // Command issue, hold while busy, stall
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd_opcode <= 8'h00;
      word_ready <= 1'b0;
      held <= 8'h00;
      taken <= 1'b0;
      lfsr <= 16'hace1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      word_ready <= slow ? lfsr[1] : 1'b1;
      if (go && !cmd_valid) begin
        cmd_valid <= 1'b1;
        cmd_opcode <= opc;
        taken <= 1'b0;
        held <= 8'h00;
      end else if (cmd_valid) begin
        if (cmd_ready) begin
          taken <= 1'b1;
        end
        if (taken || cmd_ready) begin
          if (held >= hold_cyc) begin
            cmd_valid <= 1'b0;
          end else begin
            held <= held + 8'h01;
          end
        end
      end else begin
        cmd_opcode <= lfsr[7:0];
      end
    end
  end
endmodule

// ### tb/test_identify_capability_words.sv
// Self-checking bench for the identify capability words block
// Assumes idw_defs.svh on the include path and the host model beside it
`timescale 1ns/1ps
`include "idw_defs.svh"
module test_identify_capability_words;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_valid, cmd_ready, word_valid, word_ready, sector_done;
  logic [7:0] cmd_opcode, word_index;
  logic [15:0] word_data;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [7:0] opc = 8'h00;
  logic [7:0] hold_cyc = 8'h00;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] seed = 32'd97;
  logic [31:0] r0;
  logic [23:0] wq[$];
  logic [33:0] aq[$];
  logic [23:0] e;
  logic [33:0] a;
  logic last_d = 1'b0;
  logic [1:0] c_ctrl = 2'h3;
  logic [15:0] c_cyl, c_heads, c_spt;
  logic [15:0] c_en = 16'h0040;
  logic [31:0] c_cap;
  logic [8:0] c_mult;
  logic [47:0] c_nat;
  logic [7:0] c_dma;

  always #5 core_clk = ~core_clk;

  idw_top u_idw_top (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready),
    .word_valid(word_valid), .word_ready(word_ready), .word_index(word_index),
    .word_data(word_data), .sector_done(sector_done));
  idw_host_model u_idw_host_model (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .opc(opc),
    .hold_cyc(hold_cyc), .slow(slow), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_ready(cmd_ready), .word_valid(word_valid), .word_ready(word_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_word(input logic [7:0] i);
    logic [31:0] ucap;
    ucap = (c_nat > 48'd268435455) ? 32'h00ffffff : c_nat[31:0];
    case (i)
      8'd49: return 16'h0f00 | {2'b00, c_ctrl[0], 13'h0000};
      8'd50: return 16'h4000;
      8'd51, 8'd52: return 16'h0200;
      8'd53: return 16'h0007;
      8'd54: return c_cyl;
      8'd55: return c_heads;
      8'd56: return c_spt;
      8'd57: return c_cap[15:0];
      8'd58: return c_cap[31:16];
      8'd59: return {7'h00, c_mult};
      8'd60: return ucap[15:0];
      8'd61: return ucap[31:16];
      8'd63: return {c_dma, 8'h07};
      8'd64: return 16'h0003;
      8'd65, 8'd66, 8'd67, 8'd68: return 16'h0078;
      8'd75: return 16'h001f;
      8'd76: return {13'h02e0, c_ctrl[1], 2'b10};
      8'd78: return 16'h005e;
      8'd79: return c_en;
      8'd80: return 16'h01fc;
      8'd81: return 16'h0029;
      default: return 16'h0000;
    endcase
  endfunction

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // APB transfer; ex holds {read, error, data} for the monitor
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [33:0] ex);
    aq.push_back(ex);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    check("pready setup", {31'h0, pready}, 32'h0);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 34'h0);
  endtask

  task rd(input logic [7:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h0, {2'b10, ex});
  endtask

  task cfg(input logic [1:0] ct, input logic [47:0] nat);
    logic [31:0] r;
    c_ctrl = ct;
    c_nat = nat;
    r = xs();
    c_cyl = r[15:0];
    c_heads = r[31:16];
    c_cap = xs();
    r = xs();
    c_spt = r[15:0];
    c_dma = r[23:16];
    c_mult = r[8:0];
    wr(`IDW_OFF_CTRL, {30'h0, ct});
    wr(`IDW_OFF_GEOM, {c_heads, c_cyl});
    wr(`IDW_OFF_SPT, {16'h0, c_spt});
    wr(`IDW_OFF_CURCAP, c_cap);
    wr(`IDW_OFF_MULT, {23'h0, c_mult});
    wr(`IDW_OFF_NATLO, nat[31:0]);
    wr(`IDW_OFF_NATHI, {16'h0, nat[47:32]});
    wr(`IDW_OFF_DMAACT, {24'h0, c_dma});
    r = xs();
    c_en = r[15:0] & 16'h005e;
    wr(`IDW_OFF_SATAEN, r);
    rd(`IDW_OFF_CTRL, {30'h0, ct});
    rd(`IDW_OFF_MULT, {23'h0, c_mult});
    rd(`IDW_OFF_SATAEN, {16'h0, c_en});
  endtask

  task sector(input logic [7:0] op, input logic [7:0] hold, input logic s);
    int n;
    n = 0;
    check("cmd_ready idle", {31'h0, cmd_ready}, 32'h1);
    if (op == 8'hec) begin
      for (int i = 0; i < 256; i++) begin
        wq.push_back({i[7:0], exp_word(i[7:0])});
      end
    end
    opc <= op;
    hold_cyc <= hold;
    slow <= s;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (wq.size() > 0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (20) @(posedge core_clk);
    check("word queue", wq.size(), 32'h0);
  endtask

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst === 1'b0) begin
      check("sector_done", {31'h0, sector_done}, {31'h0, last_d});
      last_d = 1'b0;
      if (word_valid === 1'b1) begin
        check("cmd_ready busy", {31'h0, cmd_ready}, 32'h0);
      end
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
        e = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
        check("word_index", {24'h0, word_index}, {24'h0, e[23:16]});
        check("word_data", {16'h0, word_data}, {16'h0, e[15:0]});
        last_d = (word_index === 8'hff);
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
        a = (aq.size() > 0) ? aq.pop_front() : 34'h0;
        check("pslverr", {31'h0, pslverr}, {31'h0, a[32]});
        if (a[33]) begin
          check("prdata", prdata, a[31:0]);
        end
      end
    end
  end

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`IDW_OFF_CTRL, 32'h3);
    rd(`IDW_OFF_SATAEN, 32'h40);
    rd(`IDW_OFF_STATUS, 32'h1);
    apb(1'b0, 8'h28, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 8'h28, xs(), {2'b01, 32'h0});
    sector(8'ha1, 8'd0, 1'b0);
    rd(`IDW_OFF_STATUS, 32'h1);
    cfg(2'h3, 48'h00000fffffff);
    sector(8'hec, 8'd20, 1'b0);
    cfg(2'h0, 48'h000010000000);
    sector(8'hec, 8'd0, 1'b1);
    r0 = xs();
    cfg(2'h2, {20'h0, r0[27:0]});
    sector(8'hec, 8'd0, 1'b1);
    cfg(2'h1, {16'h8001, xs()});
    sector(8'hec, 8'd3, 1'b0);
    rd(`IDW_OFF_STATUS, 32'h0004_0001);
    repeat (4) @(posedge core_clk);
    check("apb queue", aq.size(), 32'h0);
    wrap_up;
  end

  initial begin
    #200000;
    check("watchdog", 32'h1, 32'h0);
    wrap_up;
  end
endmodule
